// file: src/exec_pkg.sv
// Shared constants and types for the move and return execution block
package exec_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths and stack depth
   localparam int ACC_W = 8;
   localparam int FILE_ADDR_W = 7;
   localparam int PC_W = 13;
   localparam int STACK_DEPTH = 8;
   localparam int DONT_CARE_W = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions, reset values and program counter step
   localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
   localparam logic [ACC_W-1:0] ACC_RESET = 8'h00;
   localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
   localparam logic [FILE_ADDR_W-1:0] FILE_ADDR_RESET = 7'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Operations handed over by the decoder
   typedef enum logic [2:0] {
      store_accumulator_to_file,
      load_literal_to_accumulator,
      no_operation_instr,
      interrupt_return_instr,
      literal_return_instr,
      subroutine_return_instr
   } op_t;

   // Execution sequencer states
   typedef enum logic {
      st_issue,
      st_second
   } exec_state_t;

endpackage

// file: src/return_stack.sv
// Circular hardware call stack built from flip-flops
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = exec_pkg::STACK_DEPTH,
   parameter int WIDTH = exec_pkg::PC_W
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Push and pop
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   input wire logic pop_i,
   // Top entry
   output logic [WIDTH-1:0] top_of_stack_o
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [PTR_W-1:0] ptr_q;
   logic [PTR_W-1:0] top_idx;
   logic [WIDTH-1:0] mem_q [DEPTH];

   ////////////////////////////////////////////////////////////////////////////////
   // Stack pointer, pop wins over push, wraps around
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ptr_q <= '0;
      end
      else if (pop_i)
      begin
         ptr_q <= ptr_q - PTR_W'(1);
      end
      else if (push_i)
      begin
         ptr_q <= ptr_q + PTR_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Entries
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_entry
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
         if (!rst_n_i)
         begin
            mem_q[i] <= '0;
         end
         else if (push_i && !pop_i && ptr_q == PTR_W'(i))
         begin
            mem_q[i] <= push_data_i;
         end
      end
   end

   assign top_idx = ptr_q - PTR_W'(1);
   assign top_of_stack_o = mem_q[top_idx];

endmodule

// file: src/move_and_return_instr_exec.sv
// Execution of the move, no-operation and return instructions
// Operation
// - Store accumulator to file register 0..127; one word, one cycle, no flags.
// - Load 8-bit literal into accumulator; one word, one cycle, no flags.
// - Don't-care bits of the literal-load word must be zero.
// - Interrupt return pops stack into program counter; two cycles, no flags.
// - Interrupt return sets global interrupt enable, bit 7 of interrupt control.
// - Literal return loads literal into accumulator, pops stack into counter; two cycles.
// - Subroutine return pops stack into counter; interrupts and flags untouched; two cycles.
`timescale 1ns/1ps
module move_and_return_instr_exec #(
   parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH,
   parameter int DONT_CARE_W = exec_pkg::DONT_CARE_W
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Decoded instruction
   input wire logic instr_valid_i,
   input wire exec_pkg::op_t instr_op_i,
   input wire logic [exec_pkg::FILE_ADDR_W-1:0] file_addr_i,
   input wire logic [exec_pkg::ACC_W-1:0] literal_i,
   input wire logic [DONT_CARE_W-1:0] dont_care_i,
   output logic instr_ready_o,
   output logic encoding_fault_o,
   // Call push from the branch logic
   input wire logic call_push_i,
   input wire logic [exec_pkg::PC_W-1:0] call_addr_i,
   // Interrupt control register
   input wire logic interrupt_control_we_i,
   input wire logic [7:0] interrupt_control_wdata_i,
   input wire logic global_interrupt_enable_clear_i,
   output logic [7:0] interrupt_control_o,
   // File register write
   output logic file_we_o,
   output logic [exec_pkg::FILE_ADDR_W-1:0] file_addr_o,
   output logic [exec_pkg::ACC_W-1:0] file_wdata_o,
   // Core state
   output logic [exec_pkg::ACC_W-1:0] acc_o,
   output logic [exec_pkg::PC_W-1:0] pc_o,
   output logic status_we_o
);

   exec_pkg::exec_state_t st_q;
   logic ready_q;
   logic accept;
   logic is_ret;
   logic [exec_pkg::ACC_W-1:0] acc_q;
   logic [exec_pkg::PC_W-1:0] pc_q;
   logic [exec_pkg::PC_W-1:0] top_of_stack;
   logic [7:0] interrupt_control_q;
   logic file_we_q;
   logic [exec_pkg::FILE_ADDR_W-1:0] file_addr_q;
   logic [exec_pkg::ACC_W-1:0] file_wdata_q;
   logic fault_q;
   logic status_we_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Issue
   assign accept = instr_valid_i && ready_q;
   assign is_ret = instr_op_i == exec_pkg::interrupt_return_instr
                || instr_op_i == exec_pkg::literal_return_instr
                || instr_op_i == exec_pkg::subroutine_return_instr;

   // Second cycle of a return is a flush
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= exec_pkg::st_issue;
         ready_q <= 1'b1;
      end
      else
      begin
         case (st_q)
            exec_pkg::st_issue:
            begin
               if (accept && is_ret)
               begin
                  st_q <= exec_pkg::st_second;
                  ready_q <= 1'b0;
               end
            end
            exec_pkg::st_second:
            begin
               st_q <= exec_pkg::st_issue;
               ready_q <= 1'b1;
            end
            default:
            begin
               st_q <= exec_pkg::st_issue;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Call stack
   return_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(exec_pkg::PC_W)
   ) return_stack_inst (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .push_i(call_push_i),
      .push_data_i(call_addr_i),
      .pop_i(accept && is_ret),
      .top_of_stack_o(top_of_stack)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Program counter
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pc_q <= exec_pkg::PC_RESET;
      end
      else if (accept && is_ret)
      begin
         pc_q <= top_of_stack;
      end
      else if (accept)
      begin
         pc_q <= pc_q + exec_pkg::PC_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Accumulator
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         acc_q <= exec_pkg::ACC_RESET;
      end
      else if (accept && (instr_op_i == exec_pkg::load_literal_to_accumulator
                       || instr_op_i == exec_pkg::literal_return_instr))
      begin
         acc_q <= literal_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // File register write
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         file_we_q <= 1'b0;
         file_addr_q <= exec_pkg::FILE_ADDR_RESET;
         file_wdata_q <= exec_pkg::ACC_RESET;
      end
      else
      begin
         file_we_q <= accept && instr_op_i == exec_pkg::store_accumulator_to_file;
         if (accept && instr_op_i == exec_pkg::store_accumulator_to_file)
         begin
            file_addr_q <= file_addr_i;
            file_wdata_q <= acc_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt control, interrupt return set wins
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         interrupt_control_q <= exec_pkg::INTERRUPT_CONTROL_RESET;
      end
      else
      begin
         if (interrupt_control_we_i)
         begin
            interrupt_control_q <= interrupt_control_wdata_i;
         end
         else if (global_interrupt_enable_clear_i)
         begin
            interrupt_control_q[exec_pkg::GLOBAL_INTERRUPT_ENABLE_BIT] <= 1'b0;
         end
         if (accept && instr_op_i == exec_pkg::interrupt_return_instr)
         begin
            interrupt_control_q[exec_pkg::GLOBAL_INTERRUPT_ENABLE_BIT] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Encoding check and status
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fault_q <= 1'b0;
         status_we_q <= 1'b0;
      end
      else
      begin
         fault_q <= accept && instr_op_i == exec_pkg::load_literal_to_accumulator
                    && dont_care_i != '0;
         status_we_q <= 1'b0;
      end
   end

   assign instr_ready_o = ready_q;
   assign encoding_fault_o = fault_q;
   assign interrupt_control_o = interrupt_control_q;
   assign file_we_o = file_we_q;
   assign file_addr_o = file_addr_q;
   assign file_wdata_o = file_wdata_q;
   assign acc_o = acc_q;
   assign pc_o = pc_q;
   assign status_we_o = status_we_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   store_write_a: assert property (
      accept && instr_op_i == exec_pkg::store_accumulator_to_file
      |=> file_we_o && file_addr_o == $past(file_addr_i) && file_wdata_o == $past(acc_q)
          && instr_ready_o && !status_we_o)
      else $error("store did not write accumulator to file");

   literal_load_a: assert property (
      accept && instr_op_i == exec_pkg::load_literal_to_accumulator
      |=> acc_o == $past(literal_i) && !file_we_o && pc_o == $past(pc_q) + exec_pkg::PC_STEP)
      else $error("literal load wrong");

   dont_care_a: assert property (
      accept && instr_op_i == exec_pkg::load_literal_to_accumulator
      |=> encoding_fault_o == ($past(dont_care_i) != '0))
      else $error("don't-care check wrong");

   idle_hold_a: assert property (
      accept && instr_op_i == exec_pkg::no_operation_instr && !interrupt_control_we_i
      && !global_interrupt_enable_clear_i
      |=> $stable(acc_o) && !file_we_o && $stable(interrupt_control_o) && instr_ready_o
          && pc_o == $past(pc_q) + exec_pkg::PC_STEP)
      else $error("no-operation changed state");

   ret_two_cycle_a: assert property (
      accept && is_ret |=> !instr_ready_o ##1 instr_ready_o)
      else $error("return not two cycles");

   ret_pc_a: assert property (
      accept && is_ret |=> pc_o == $past(top_of_stack) ##1 $stable(pc_o))
      else $error("return did not load top of stack");

   enable_set_a: assert property (
      accept && instr_op_i == exec_pkg::interrupt_return_instr
      |=> interrupt_control_o[exec_pkg::GLOBAL_INTERRUPT_ENABLE_BIT])
      else $error("interrupt return did not enable interrupts");

   literal_ret_a: assert property (
      accept && instr_op_i == exec_pkg::literal_return_instr
      |=> acc_o == $past(literal_i) && pc_o == $past(top_of_stack) && !status_we_o)
      else $error("literal return wrong");

   return_keeps_enable_a: assert property (
      accept && instr_op_i == exec_pkg::subroutine_return_instr && !interrupt_control_we_i
      && !global_interrupt_enable_clear_i
      |=> $stable(interrupt_control_o) && $stable(acc_o))
      else $error("subroutine return touched interrupts");

   store_seen_c: cover property (accept && instr_op_i == exec_pkg::store_accumulator_to_file);
   iret_seen_c: cover property (accept && instr_op_i == exec_pkg::interrupt_return_instr);
   lret_seen_c: cover property (accept && instr_op_i == exec_pkg::literal_return_instr);
   back_to_back_c: cover property (accept && is_ret ##2 accept && is_ret);

endmodule

// file: bench/move_and_return_instr_exec_tb.sv
// Self-checking testbench for the move and return execution block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module move_and_return_instr_exec_tb;

   ////////////////////////////////////////////////////////////////////////////////
   // Signals
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic instr_valid_i = 1'b0;
   exec_pkg::op_t instr_op_i = exec_pkg::no_operation_instr;
   logic [exec_pkg::FILE_ADDR_W-1:0] file_addr_i = 7'h00;
   logic [exec_pkg::ACC_W-1:0] literal_i = 8'h00;
   logic [exec_pkg::DONT_CARE_W-1:0] dont_care_i = 2'h0;
   logic call_push_i = 1'b0;
   logic [exec_pkg::PC_W-1:0] call_addr_i = 13'h0000;
   logic interrupt_control_we_i = 1'b0;
   logic [7:0] interrupt_control_wdata_i = 8'h00;
   logic global_interrupt_enable_clear_i = 1'b0;
   logic instr_ready_o;
   logic encoding_fault_o;
   logic [7:0] interrupt_control_o;
   logic file_we_o;
   logic [exec_pkg::FILE_ADDR_W-1:0] file_addr_o;
   logic [exec_pkg::ACC_W-1:0] file_wdata_o;
   logic [exec_pkg::ACC_W-1:0] acc_o;
   logic [exec_pkg::PC_W-1:0] pc_o;
   logic status_we_o;
   int n_mismatch = 0;
   int check_count = 0;
   logic [exec_pkg::PC_W-1:0] exp_pc;

   move_and_return_instr_exec move_and_return_instr_exec_inst (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
      .file_addr_i(file_addr_i), .literal_i(literal_i), .dont_care_i(dont_care_i),
      .instr_ready_o(instr_ready_o), .encoding_fault_o(encoding_fault_o),
      .call_push_i(call_push_i), .call_addr_i(call_addr_i),
      .interrupt_control_we_i(interrupt_control_we_i),
      .interrupt_control_wdata_i(interrupt_control_wdata_i),
      .global_interrupt_enable_clear_i(global_interrupt_enable_clear_i),
      .interrupt_control_o(interrupt_control_o),
      .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
      .acc_o(acc_o), .pc_o(pc_o), .status_we_o(status_we_o)
   );

   initial
   begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic results();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Presents one instruction; returns just after the taking edge has settled
   task automatic issue(input exec_pkg::op_t op, input logic [6:0] a, input logic [7:0] k,
                        input logic [1:0] dc);
      int n;
      n = 0;
      while (instr_ready_o !== 1'b1 && n < 10)
      begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      if (instr_ready_o !== 1'b1)
      begin
         n_mismatch++;
         results();
      end
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b1;
      instr_op_i <= op;
      file_addr_i <= a;
      literal_i <= k;
      dont_care_i <= dc;
      @(posedge sys_clk_i);
      instr_valid_i <= 1'b0;
      dont_care_i <= 2'h0;
      #1;
   endtask

   task automatic push(input logic [12:0] a);
      @(posedge sys_clk_i);
      call_push_i <= 1'b1;
      call_addr_i <= a;
      @(posedge sys_clk_i);
      call_push_i <= 1'b0;
   endtask

   // Return taken: counter from stack, one dead cycle, then ready again
   task automatic check_return(input logic [12:0] exp_top);
      `CHK(pc_o, exp_top)
      `CHK(instr_ready_o, 1'b0)
      `CHK(status_we_o, 1'b0)
      @(posedge sys_clk_i);
      #1;
      `CHK(instr_ready_o, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      `CHK(pc_o, exec_pkg::PC_RESET)
      `CHK(acc_o, exec_pkg::ACC_RESET)
      `CHK(interrupt_control_o, exec_pkg::INTERRUPT_CONTROL_RESET)
      `CHK(instr_ready_o, 1'b1)
      `CHK(file_we_o, 1'b0)
   endtask

   task automatic t_literal();
      issue(exec_pkg::load_literal_to_accumulator, 7'h00, 8'hFF, 2'h0);
      exp_pc = exp_pc + 13'h0001;
      `CHK(acc_o, 8'hFF)
      `CHK(pc_o, exp_pc)
      `CHK(encoding_fault_o, 1'b0)
      `CHK(status_we_o, 1'b0)
      issue(exec_pkg::load_literal_to_accumulator, 7'h00, 8'h00, 2'h2);
      exp_pc = exp_pc + 13'h0001;
      `CHK(acc_o, 8'h00)
      `CHK(encoding_fault_o, 1'b1)
      @(posedge sys_clk_i);
      #1;
      `CHK(encoding_fault_o, 1'b0)
   endtask

   task automatic t_store();
      issue(exec_pkg::load_literal_to_accumulator, 7'h00, 8'h4F, 2'h0);
      exp_pc = exp_pc + 13'h0001;
      issue(exec_pkg::store_accumulator_to_file, 7'h7F, 8'h11, 2'h0);
      exp_pc = exp_pc + 13'h0001;
      `CHK(file_we_o, 1'b1)
      `CHK(file_addr_o, 7'h7F)
      `CHK(file_wdata_o, 8'h4F)
      `CHK(acc_o, 8'h4F)
      `CHK(pc_o, exp_pc)
      `CHK(status_we_o, 1'b0)
      @(posedge sys_clk_i);
      #1;
      `CHK(file_we_o, 1'b0)
   endtask

   task automatic t_no_operation();
      issue(exec_pkg::no_operation_instr, 7'h55, 8'hAA, 2'h0);
      exp_pc = exp_pc + 13'h0001;
      `CHK(pc_o, exp_pc)
      `CHK(acc_o, 8'h4F)
      `CHK(file_we_o, 1'b0)
      `CHK(interrupt_control_o, 8'h00)
   endtask

   task automatic t_returns();
      push(13'h0ABC);
      push(13'h1FFF);
      issue(exec_pkg::subroutine_return_instr, 7'h00, 8'h00, 2'h0);
      `CHK(interrupt_control_o, 8'h00)
      `CHK(acc_o, 8'h4F)
      check_return(13'h1FFF);
      issue(exec_pkg::literal_return_instr, 7'h00, 8'hA5, 2'h0);
      `CHK(acc_o, 8'hA5)
      check_return(13'h0ABC);
   endtask

   task automatic t_iret();
      @(posedge sys_clk_i);
      interrupt_control_we_i <= 1'b1;
      interrupt_control_wdata_i <= 8'hBC;
      @(posedge sys_clk_i);
      interrupt_control_we_i <= 1'b0;
      global_interrupt_enable_clear_i <= 1'b1;
      @(posedge sys_clk_i);
      global_interrupt_enable_clear_i <= 1'b0;
      #1;
      `CHK(interrupt_control_o, 8'h3C)
      push(13'h0123);
      issue(exec_pkg::interrupt_return_instr, 7'h00, 8'h00, 2'h0);
      `CHK(interrupt_control_o, 8'hBC)
      `CHK(acc_o, 8'hA5)
      check_return(13'h0123);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      exp_pc = exec_pkg::PC_RESET;
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      #1;
      t_reset();
      t_literal();
      t_store();
      t_no_operation();
      t_returns();
      t_iret();
      results();
   end

endmodule
